// File: rtl/ccs_clk_if.sv
// link between the register bank and the clock source monitor
`timescale 1ns/1ps
interface ccs_clk_if;
	logic ext_clock_in_en;
	logic oscillator_en;
	logic [1:0] xtal_freq_sel;
	logic clock_out_en;
	logic clock_missing_flag;
	logic clock_out;
	modport ctrl (
		output ext_clock_in_en, oscillator_en, xtal_freq_sel, clock_out_en,
		input clock_missing_flag, clock_out
	);
	modport mon (
		input ext_clock_in_en, oscillator_en, xtal_freq_sel, clock_out_en,
		output clock_missing_flag, clock_out
	);
endinterface

// File: rtl/ccs_clk_mon.sv
// clock source monitor, fallback and clock output divider
`timescale 1ns/1ps
module ccs_clk_mon
	import ccs_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ext_clock_pin,
	input wire logic xtal_osc_pin,
	ccs_clk_if.mon cif
);
	typedef struct packed {
		logic src_prev;
		logic [IDLE_W-1:0] idle_cnt;
		logic missing;
		logic [2:0] div_cnt;
		logic [INT_W-1:0] int_cnt;
		logic clk_out;
	} ccs_mon_state_s;

	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(CLK_MISS_CYC - 1);
	localparam logic [INT_W-1:0] INT_LAST = INT_W'(INT_HALF_CYC - 1);

	ccs_mon_state_s st_reg;
	ccs_mon_state_s st_next;
	logic any_sel;
	logic src;
	logic src_edge;
	logic use_int;
	logic tick;
	logic [2:0] divisor;

	always_comb begin
		// ext wins if software breaks the one-source-only contract
		any_sel = cif.ext_clock_in_en | cif.oscillator_en;
		src = cif.ext_clock_in_en ? ext_clock_pin : xtal_osc_pin;
		src_edge = src != st_reg.src_prev;
		case (cif.xtal_freq_sel)
			XSEL_14M: divisor = DIV_EDGES_14M;
			XSEL_7M: divisor = DIV_EDGES_7M;
			default: divisor = DIV_EDGES_3M;
		endcase
		st_next = st_reg;
		st_next.src_prev = src;
		tick = 1'b0;
		if (!any_sel) begin
			st_next.idle_cnt = '0;
			st_next.missing = 1'b0;
		end else if (src_edge) begin
			st_next.idle_cnt = '0;
			st_next.missing = 1'b0;
		end else if (st_reg.idle_cnt == IDLE_LAST) begin
			st_next.missing = 1'b1;
		end else begin
			st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
		end
		use_int = !any_sel || st_reg.missing;
		if (use_int) begin
			st_next.div_cnt = '0;
			st_next.int_cnt = (st_reg.int_cnt == INT_LAST) ? '0 : st_reg.int_cnt + 1'b1;
			tick = st_reg.int_cnt == INT_LAST;
		end else begin
			st_next.int_cnt = '0;
			if (src_edge) begin
				tick = (st_reg.div_cnt + 3'h1) >= divisor;
				st_next.div_cnt = tick ? 3'h0 : st_reg.div_cnt + 3'h1;
			end
		end
		if (!cif.clock_out_en) begin
			st_next.clk_out = 1'b0;
		end else if (tick) begin
			st_next.clk_out = ~st_reg.clk_out;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign cif.clock_missing_flag = st_reg.missing;
	assign cif.clock_out = st_reg.clk_out;

	miss_needs_sel_a: assert property (@(posedge clock) disable iff (sys_rst)
		!any_sel |=> !st_reg.missing)
		else $error("clock missing raised with no external source selected");
	out_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
		!cif.clock_out_en |=> !st_reg.clk_out)
		else $error("clock output toggled while disabled");
endmodule // ccs_clk_mon

// File: rtl/ccs_pkg.sv
// constants for the clock configuration and supply status block
package ccs_pkg;
	// ********************
	// register map
	// ********************
	localparam logic [7:0] ADDR_CLOCK_CFG = 8'h1d;
	localparam logic [7:0] ADDR_STATUS = 8'h1e;
	localparam logic [7:0] CLOCK_CFG_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
	// clock configuration fields
	localparam int BIT_SUPPLY_WARN_IRQ_EN = 7;
	localparam int BIT_TX_PIN_OVERRIDE = 6;
	localparam int BIT_CLOCK_MISSING = 5;
	localparam int BIT_CLOCK_OUT_EN = 4;
	localparam int BIT_XTAL_SEL_HI = 3;
	localparam int BIT_XTAL_SEL_LO = 2;
	localparam int BIT_EXT_CLOCK_IN_EN = 1;
	localparam int BIT_OSCILLATOR_EN = 0;
	// status fields: sticky nibble above live nibble, same order
	localparam int STICKY_LSB = 4;
	localparam int IDX_THERM_SHUTDOWN = 3;
	localparam int IDX_THERM_WARNING = 2;
	localparam int IDX_SUPPLY_UNDER = 1;
	localparam int IDX_SUPPLY_WARNING = 0;
	localparam int NUM_CHAN = 2;
	// ********************
	// divider and timing
	// ********************
	localparam logic [1:0] XSEL_14M = 2'h0;
	localparam logic [1:0] XSEL_7M = 2'h1;
	localparam logic [2:0] DIV_EDGES_14M = 3'h4;
	localparam logic [2:0] DIV_EDGES_7M = 3'h2;
	localparam logic [2:0] DIV_EDGES_3M = 3'h1;
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLK_MISS_NS = 2000;
	localparam int CLK_MISS_CYC = CLK_MISS_NS / CLK_PERIOD_NS;
	localparam int INT_HALF_NS = 136;
	localparam int INT_HALF_CYC = INT_HALF_NS / CLK_PERIOD_NS;
	localparam int IDLE_W = 6;
	localparam int INT_W = 2;
endpackage

// File: rtl/ccs_top.sv
// clock configuration and supply status register bank
`timescale 1ns/1ps
module ccs_top
	import ccs_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic ext_clock_pin,
	input wire logic xtal_osc_pin,
	input wire logic [1:0] tx_pin,
	input wire logic [1:0] transmit_enable_pin,
	input wire logic [1:0] tx_reg_bit,
	input wire logic [1:0] transmit_enable_reg_bit,
	input wire logic therm_shutdown_det,
	input wire logic temp_above_135,
	input wire logic temp_below_120,
	input wire logic supply_below_9v,
	input wire logic supply_below_18v,
	input wire logic supply_above_15v5,
	output logic [1:0] line_output,
	output logic [1:0] line_output_en,
	output logic clock_out_pin,
	output logic status_irq
);
	// ********************
	// state
	// ********************
	typedef struct packed {
		logic supply_warn_irq_en;
		logic tx_pin_override;
		logic clock_out_en;
		logic [1:0] xtal_freq_sel;
		logic ext_clock_in_en;
		logic oscillator_en;
		logic [3:0] live;
		logic [3:0] sticky;
		logic [7:0] rdata;
		logic irq;
		logic [1:0] line_out;
		logic [1:0] line_oe;
		logic clk_out;
	} ccs_top_state_s;

	ccs_top_state_s st_reg;
	ccs_top_state_s st_next;

	ccs_clk_if cif ();

	logic wr_cfg;
	logic rd_status;
	logic [3:0] rise;
	logic [7:0] cfg_view;
	logic [7:0] status_view;
	logic [3:0] irq_src;
	logic [1:0] drv_val;
	logic [1:0] drv_en;

	// ********************
	// clock source monitor
	// ********************
	assign cif.ext_clock_in_en = st_reg.ext_clock_in_en;
	assign cif.oscillator_en = st_reg.oscillator_en;
	assign cif.xtal_freq_sel = st_reg.xtal_freq_sel;
	assign cif.clock_out_en = st_reg.clock_out_en;

	ccs_clk_mon u_mon (
		.clock(clock),
		.sys_rst(sys_rst),
		.ext_clock_pin(ext_clock_pin),
		.xtal_osc_pin(xtal_osc_pin),
		.cif(cif)
	);

	// ********************
	// line driver steering
	// ********************
	generate
		for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
			// pins are dead to the driver while the override is set
			assign drv_val[ch] = st_reg.tx_pin_override ? tx_reg_bit[ch] : tx_pin[ch];
			assign drv_en[ch] = st_reg.tx_pin_override ?
				transmit_enable_reg_bit[ch] : transmit_enable_pin[ch];
		end
	endgenerate

	// ********************
	// register views
	// ********************
	always_comb begin
		cfg_view = CLOCK_CFG_RESET;
		cfg_view[BIT_SUPPLY_WARN_IRQ_EN] = st_reg.supply_warn_irq_en;
		cfg_view[BIT_TX_PIN_OVERRIDE] = st_reg.tx_pin_override;
		cfg_view[BIT_CLOCK_MISSING] = cif.clock_missing_flag;
		cfg_view[BIT_CLOCK_OUT_EN] = st_reg.clock_out_en;
		cfg_view[BIT_XTAL_SEL_HI:BIT_XTAL_SEL_LO] = st_reg.xtal_freq_sel;
		cfg_view[BIT_EXT_CLOCK_IN_EN] = st_reg.ext_clock_in_en;
		cfg_view[BIT_OSCILLATOR_EN] = st_reg.oscillator_en;
		status_view = {st_reg.sticky, st_reg.live};
	end

	// ********************
	// next state
	// ********************
	always_comb begin
		st_next = st_reg;
		wr_cfg = reg_wr && (reg_addr == ADDR_CLOCK_CFG);
		rd_status = reg_rd && (reg_addr == ADDR_STATUS);

		// missing flag and status are never written by software
		if (wr_cfg) begin
			st_next.supply_warn_irq_en = reg_wdata[BIT_SUPPLY_WARN_IRQ_EN];
			st_next.tx_pin_override = reg_wdata[BIT_TX_PIN_OVERRIDE];
			st_next.clock_out_en = reg_wdata[BIT_CLOCK_OUT_EN];
			st_next.xtal_freq_sel = reg_wdata[BIT_XTAL_SEL_HI:BIT_XTAL_SEL_LO];
			st_next.ext_clock_in_en = reg_wdata[BIT_EXT_CLOCK_IN_EN];
			st_next.oscillator_en = reg_wdata[BIT_OSCILLATOR_EN];
		end

		// live condition flags
		st_next.live[IDX_THERM_SHUTDOWN] = therm_shutdown_det;
		// comparator outputs are treated as exclusive; set side wins a tie
		if (temp_above_135) begin
			st_next.live[IDX_THERM_WARNING] = 1'b1;
		end else if (temp_below_120) begin
			st_next.live[IDX_THERM_WARNING] = 1'b0;
		end
		st_next.live[IDX_SUPPLY_UNDER] = supply_below_9v;
		// follows the supply even when its interrupt is masked
		if (supply_below_18v) begin
			st_next.live[IDX_SUPPLY_WARNING] = 1'b1;
		end else if (supply_above_15v5) begin
			st_next.live[IDX_SUPPLY_WARNING] = 1'b0;
		end

		// sticky flags: rising edge of live sets, status read clears
		rise = st_next.live & ~st_reg.live;
		st_next.sticky = (st_reg.sticky & ~{4{rd_status}}) | rise;

		irq_src = st_next.sticky;
		irq_src[IDX_SUPPLY_WARNING] = st_next.sticky[IDX_SUPPLY_WARNING] &
			st_next.supply_warn_irq_en;
		st_next.irq = |irq_src;

		// read data held until the next read
		if (reg_rd) begin
			case (reg_addr)
				ADDR_CLOCK_CFG: st_next.rdata = cfg_view;
				ADDR_STATUS: st_next.rdata = status_view;
				default: st_next.rdata = RDATA_UNMAPPED;
			endcase
		end

		st_next.line_out = drv_val;
		st_next.line_oe = drv_en;
		st_next.clk_out = cif.clock_out;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign line_output = st_reg.line_out;
	assign line_output_en = st_reg.line_oe;
	assign clock_out_pin = st_reg.clk_out;
	assign status_irq = st_reg.irq;

	// ********************
	// checks
	// ********************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	override_drive_a: assert property (
		st_reg.tx_pin_override |=> line_output == $past(tx_reg_bit) &&
			line_output_en == $past(transmit_enable_reg_bit))
		else $error("line output did not follow register bits under override");
	pin_drive_a: assert property (
		!st_reg.tx_pin_override |=> line_output == $past(tx_pin) &&
			line_output_en == $past(transmit_enable_pin))
		else $error("line output did not follow pins without override");
	sticky_rise_a: assert property (
		$rose(st_reg.sticky[IDX_THERM_WARNING]) |->
			$rose(st_reg.live[IDX_THERM_WARNING]))
		else $error("sticky flag set without a live rising edge");
	read_clear_a: assert property (
		rd_status && (st_next.live & ~st_reg.live) == 4'h0 |=>
			st_reg.sticky == 4'h0 && st_reg.live == $past(st_next.live))
		else $error("status read did not clear sticky flags");
	read_race_a: assert property (
		rd_status && |rise |=> (st_reg.sticky & $past(rise)) == $past(rise))
		else $error("sticky set lost against a status read");
	irq_masked_a: assert property (
		st_reg.sticky == 4'h1 && !st_reg.supply_warn_irq_en |-> !status_irq)
		else $error("masked supply warning raised the interrupt");
	irq_follow_a: assert property (
		|st_reg.sticky[3:1] |-> status_irq)
		else $error("sticky flag did not raise the interrupt");
	warn_hyst_a: assert property (
		st_reg.live[IDX_THERM_WARNING] && !temp_above_135 && !temp_below_120 |=>
			st_reg.live[IDX_THERM_WARNING])
		else $error("thermal warning dropped inside the hysteresis band");
	supply_hyst_a: assert property (
		st_reg.live[IDX_SUPPLY_WARNING] && !supply_above_15v5 && !supply_below_18v |=>
			st_reg.live[IDX_SUPPLY_WARNING])
		else $error("supply warning did not hold between thresholds");
	missing_ro_a: assert property (
		wr_cfg && reg_wdata[BIT_CLOCK_MISSING] && !cif.ext_clock_in_en &&
			!cif.oscillator_en |=> !cif.clock_missing_flag)
		else $error("write reached the clock missing flag");
	shutdown_live_a: assert property (
		therm_shutdown_det |=> st_reg.live[IDX_THERM_SHUTDOWN])
		else $error("thermal shutdown flag did not follow the detector");
	undervolt_a: assert property (
		!supply_below_9v |=> !st_reg.live[IDX_SUPPLY_UNDER])
		else $error("undervoltage flag stayed set above threshold");

	// ********************
	// register port checks
	// ********************
	cfg_write_a: assert property (
		wr_cfg |=> (cfg_view & 8'hdf) == ($past(reg_wdata) & 8'hdf))
		else $error("clock configuration write did not land");
	cfg_hold_a: assert property (
		!wr_cfg |=> $stable(st_reg.xtal_freq_sel) && $stable(st_reg.clock_out_en) &&
			$stable(st_reg.ext_clock_in_en) && $stable(st_reg.oscillator_en))
		else $error("clock configuration changed without a write");
	status_write_a: assert property (
		reg_wr && !reg_rd |=> st_reg.sticky == ($past(st_reg.sticky) | $past(rise)))
		else $error("register write disturbed the sticky flags");
	rdata_status_a: assert property (
		rd_status |=> reg_rdata == $past(status_view))
		else $error("status read returned the wrong value");
	rdata_cfg_a: assert property (
		reg_rd && reg_addr == ADDR_CLOCK_CFG |=> reg_rdata == $past(cfg_view))
		else $error("configuration read returned the wrong value");
	rdata_unmapped_a: assert property (
		reg_rd && reg_addr != ADDR_CLOCK_CFG && reg_addr != ADDR_STATUS |=>
			reg_rdata == RDATA_UNMAPPED)
		else $error("unmapped read returned data");
	rdata_hold_a: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	// ********************
	// status flag checks
	// ********************
	sticky_hold_a: assert property (
		!rd_status |=> (st_reg.sticky & $past(st_reg.sticky)) == $past(st_reg.sticky))
		else $error("sticky flag dropped without a status read");
	live_read_a: assert property (
		rd_status |=> st_reg.live == $past(st_next.live))
		else $error("status read disturbed the live flags");
	rise_sets_a: assert property (
		|rise |=> (st_reg.sticky & $past(rise)) == $past(rise))
		else $error("live rising edge did not set its sticky flag");
	shdn_sticky_a: assert property (
		$rose(st_reg.sticky[IDX_THERM_SHUTDOWN]) |-> $rose(st_reg.live[IDX_THERM_SHUTDOWN]))
		else $error("shutdown sticky set without a live rising edge");
	uv_sticky_a: assert property (
		$rose(st_reg.sticky[IDX_SUPPLY_UNDER]) |-> $rose(st_reg.live[IDX_SUPPLY_UNDER]))
		else $error("undervoltage sticky set without a live rising edge");
	vwarn_sticky_a: assert property (
		$rose(st_reg.sticky[IDX_SUPPLY_WARNING]) |-> $rose(st_reg.live[IDX_SUPPLY_WARNING]))
		else $error("supply warning sticky set without a live rising edge");
	uv_set_a: assert property (
		supply_below_9v |=> st_reg.live[IDX_SUPPLY_UNDER])
		else $error("undervoltage flag missed the comparator");
	shdn_clear_a: assert property (
		!therm_shutdown_det |=> !st_reg.live[IDX_THERM_SHUTDOWN])
		else $error("shutdown flag stayed set after shutdown ended");
	warn_set_a: assert property (
		temp_above_135 |=> st_reg.live[IDX_THERM_WARNING])
		else $error("thermal warning missed the upper threshold");
	warn_clear_a: assert property (
		temp_below_120 && !temp_above_135 |=> !st_reg.live[IDX_THERM_WARNING])
		else $error("thermal warning missed the lower threshold");
	warn_rise_a: assert property (
		$rose(st_reg.live[IDX_THERM_WARNING]) |-> $past(temp_above_135))
		else $error("thermal warning set below the upper threshold");
	warn_fall_a: assert property (
		$fell(st_reg.live[IDX_THERM_WARNING]) |-> $past(temp_below_120))
		else $error("thermal warning cleared above the lower threshold");
	vwarn_set_a: assert property (
		supply_below_18v |=> st_reg.live[IDX_SUPPLY_WARNING])
		else $error("supply warning missed the warning level");
	vwarn_clear_a: assert property (
		supply_above_15v5 && !supply_below_18v |=> !st_reg.live[IDX_SUPPLY_WARNING])
		else $error("supply warning missed the release level");
	vwarn_rise_a: assert property (
		$rose(st_reg.live[IDX_SUPPLY_WARNING]) |-> $past(supply_below_18v))
		else $error("supply warning set above the warning level");
	vwarn_fall_a: assert property (
		$fell(st_reg.live[IDX_SUPPLY_WARNING]) |-> $past(supply_above_15v5))
		else $error("supply warning cleared below the release level");

	// ********************
	// interrupt and clock output checks
	// ********************
	irq_unmasked_a: assert property (
		st_reg.sticky[IDX_SUPPLY_WARNING] && st_reg.supply_warn_irq_en |-> status_irq)
		else $error("enabled supply warning did not raise the interrupt");
	irq_quiet_a: assert property (
		st_reg.sticky == 4'h0 |-> !status_irq)
		else $error("interrupt raised with no sticky flag set");
	irq_rise_a: assert property (
		|rise[3:1] |=> status_irq)
		else $error("new sticky flag did not raise the interrupt");
	irq_drop_a: assert property (
		rd_status && rise == 4'h0 |=> !status_irq)
		else $error("interrupt stayed up after the status read");
	clkout_off_a: assert property (
		!st_reg.clock_out_en |=> ##1 !clock_out_pin)
		else $error("clock output pin active while disabled");
	clkout_lag_a: assert property (
		1'b1 |=> clock_out_pin == $past(cif.clock_out))
		else $error("clock output pin did not follow the divider");
endmodule // ccs_top

// File: testbench/tb_clock_config_and_supply_status.sv
// self-checking bench for the clock configuration and supply status registers
`timescale 1ns/1ps
module tb_clock_config_and_supply_status;
	import ccs_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic ext_clock_pin = 1'b0;
	logic xtal_osc_pin = 1'b0;
	logic [1:0] tx_pin = 2'h0;
	logic [1:0] transmit_enable_pin = 2'h0;
	logic [1:0] tx_reg_bit = 2'h0;
	logic [1:0] transmit_enable_reg_bit = 2'h0;
	logic therm_shutdown_det = 1'b0;
	logic temp_above_135 = 1'b0;
	logic temp_below_120 = 1'b1;
	logic supply_below_9v = 1'b0;
	logic supply_below_18v = 1'b0;
	logic supply_above_15v5 = 1'b1;
	logic [1:0] line_output;
	logic [1:0] line_output_en;
	logic clock_out_pin;
	logic status_irq;
	logic src_run = 1'b0;
	logic xtal_run = 1'b0;
	int error_cnt = 0;
	int comparisons = 0;

	ccs_top u_ccs_top (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.ext_clock_pin(ext_clock_pin), .xtal_osc_pin(xtal_osc_pin), .tx_pin(tx_pin),
		.transmit_enable_pin(transmit_enable_pin), .tx_reg_bit(tx_reg_bit),
		.transmit_enable_reg_bit(transmit_enable_reg_bit),
		.therm_shutdown_det(therm_shutdown_det), .temp_above_135(temp_above_135),
		.temp_below_120(temp_below_120), .supply_below_9v(supply_below_9v),
		.supply_below_18v(supply_below_18v), .supply_above_15v5(supply_above_15v5),
		.line_output(line_output), .line_output_en(line_output_en),
		.clock_out_pin(clock_out_pin), .status_irq(status_irq));

	always #20 clock = ~clock;

	// slow external clock source: one edge every 4 system cycles
	always begin
		repeat (4) @(posedge clock);
		if (src_run) #1 ext_clock_pin = ~ext_clock_pin;
	end

	// crystal source: one edge every 2 system cycles
	always begin
		repeat (2) @(posedge clock);
		if (xtal_run) #1 xtal_osc_pin = ~xtal_osc_pin;
	end

	// ********************
	// shared tasks
	// ********************
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clock);
		#1 reg_wr = 1'b1;
		reg_addr = addr;
		reg_wdata = data;
		@(posedge clock);
		#1 reg_wr = 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clock);
		#1 reg_rd = 1'b1;
		reg_addr = addr;
		@(posedge clock);
		#1 reg_rd = 1'b0;
		data = reg_rdata;
	endtask

	task automatic rd_check(input string name, input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(addr, d);
		check(name, d, exp);
	endtask

	task automatic count_toggles(input int cycles, output int n);
		logic prev;
		n = 0;
		prev = clock_out_pin;
		repeat (cycles) begin
			@(posedge clock);
			#1;
			if (clock_out_pin !== prev) n++;
			prev = clock_out_pin;
		end
	endtask

	// ********************
	// scenarios
	// ********************
	task automatic test_reset_and_access();
		rd_check("cfg_reset", ADDR_CLOCK_CFG, 8'h00);
		rd_check("status_reset", ADDR_STATUS, 8'h00);
		rd_check("unmapped", 8'h1f, RDATA_UNMAPPED);
		wr_reg(ADDR_CLOCK_CFG, 8'hfc);
		rd_check("cfg_ro_bit", ADDR_CLOCK_CFG, 8'hdc);
		wr_reg(ADDR_CLOCK_CFG, 8'h00);
		wr_reg(ADDR_STATUS, 8'hff);
		rd_check("status_ro", ADDR_STATUS, 8'h00);
	endtask

	task automatic test_line_steering();
		tx_pin = 2'h1;
		transmit_enable_pin = 2'h2;
		tx_reg_bit = 2'h2;
		transmit_enable_reg_bit = 2'h1;
		wait_cyc(2);
		check("line_pins", {6'h0, line_output}, 8'h01);
		check("line_en_pins", {6'h0, line_output_en}, 8'h02);
		wr_reg(ADDR_CLOCK_CFG, 8'h40);
		wait_cyc(2);
		check("line_regs", {6'h0, line_output}, 8'h02);
		check("line_en_regs", {6'h0, line_output_en}, 8'h01);
		wr_reg(ADDR_CLOCK_CFG, 8'h00);
		wait_cyc(2);
		check("line_back", {6'h0, line_output}, 8'h01);
		check("line_en_back", {6'h0, line_output_en}, 8'h02);
	endtask

	task automatic test_status_flags();
		logic [7:0] d;
		supply_below_9v = 1'b1;
		wait_cyc(2);
		check("irq_uv", {7'h0, status_irq}, 8'h01);
		rd_check("uv_set", ADDR_STATUS, 8'h22);
		rd_check("uv_cleared", ADDR_STATUS, 8'h02);
		check("irq_cleared", {7'h0, status_irq}, 8'h00);
		supply_below_9v = 1'b0;
		wait_cyc(2);
		rd_check("uv_gone", ADDR_STATUS, 8'h00);
		temp_below_120 = 1'b0;
		temp_above_135 = 1'b1;
		wait_cyc(2);
		temp_above_135 = 1'b0;
		wait_cyc(2);
		rd_check("warn_held", ADDR_STATUS, 8'h44);
		temp_below_120 = 1'b1;
		wait_cyc(2);
		rd_check("warn_gone", ADDR_STATUS, 8'h00);
		supply_above_15v5 = 1'b0;
		supply_below_18v = 1'b1;
		wait_cyc(2);
		check("irq_masked", {7'h0, status_irq}, 8'h00);
		supply_below_18v = 1'b0;
		wr_reg(ADDR_CLOCK_CFG, 8'h80);
		wait_cyc(1);
		check("irq_enabled", {7'h0, status_irq}, 8'h01);
		rd_check("vwarn_held", ADDR_STATUS, 8'h11);
		supply_above_15v5 = 1'b1;
		wait_cyc(2);
		rd_check("vwarn_gone", ADDR_STATUS, 8'h00);
		wr_reg(ADDR_CLOCK_CFG, 8'h00);
		// rising shutdown lands on the same edge as a status read
		@(posedge clock);
		#1 reg_rd = 1'b1;
		reg_addr = ADDR_STATUS;
		therm_shutdown_det = 1'b1;
		@(posedge clock);
		#1 reg_rd = 1'b0;
		rd_reg(ADDR_STATUS, d);
		check("set_beats_clear", d, 8'h88);
		therm_shutdown_det = 1'b0;
		wait_cyc(2);
		rd_check("shdn_gone", ADDR_STATUS, 8'h00);
	endtask

	task automatic test_clock_out();
		int n;
		int exp_t[3] = '{10, 20, 40};
		src_run = 1'b1;
		for (int s = 0; s < 3; s++) begin
			wr_reg(ADDR_CLOCK_CFG, 8'h12 | (8'(s) << 2));
			wait_cyc(40);
			count_toggles(160, n);
			check("div_rate", 8'(n >= exp_t[s] - 1 && n <= exp_t[s] + 1), 8'h01);
		end
		wr_reg(ADDR_CLOCK_CFG, 8'h02);
		wait_cyc(4);
		count_toggles(80, n);
		check("clkout_off", 8'(n), 8'h00);
		check("clkout_low", {7'h0, clock_out_pin}, 8'h00);
		src_run = 1'b0;
		// flag trusted only once the source timeout has surely run out
		wait_cyc(70);
		rd_check("clk_missing", ADDR_CLOCK_CFG, 8'h22);
		wr_reg(ADDR_CLOCK_CFG, 8'h12);
		count_toggles(60, n);
		n = n - 60 / INT_HALF_CYC;
		check("fallback_runs", 8'(n >= -1 && n <= 1), 8'h01);
		src_run = 1'b1;
		wait_cyc(20);
		rd_check("clk_back", ADDR_CLOCK_CFG, 8'h12);
		wr_reg(ADDR_CLOCK_CFG, 8'h00);
		// crystal selected while the clock pin is dead: pin must be ignored
		src_run = 1'b0;
		xtal_run = 1'b1;
		wr_reg(ADDR_CLOCK_CFG, 8'h11);
		wait_cyc(40);
		count_toggles(160, n);
		check("xtal_rate", 8'(n >= 19 && n <= 21), 8'h01);
		rd_check("xtal_no_miss", ADDR_CLOCK_CFG, 8'h11);
		xtal_run = 1'b0;
		wr_reg(ADDR_CLOCK_CFG, 8'h00);
	endtask

	// ********************
	// main sequence and watchdog
	// ********************
	initial begin
		repeat (3) @(posedge clock);
		#1 sys_rst = 1'b0;
		test_reset_and_access();
		test_line_steering();
		test_status_flags();
		test_clock_out();
		report_and_stop();
	end

	// whole run is about 1130 cycles; allow over thirteen times that
	initial begin
		#600000;
		error_cnt++;
		report_and_stop();
	end
endmodule // tb_clock_config_and_supply_status
